//--- port_devctl_pkg.sv
// constants for the per-port device control register bank
package port_devctl_pkg;

    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int SEL_W = 4;

    // register byte addresses
    localparam logic [11:0] PORT_DEVICE_CONTROL_OFFSET = 12'hC8;
    localparam logic [11:0] PAYLOAD_CAP_STATUS_OFFSET = 12'h000;

    // field positions in port_device_control
    localparam int CORR_ERR_EN_BIT = 0;
    localparam int NONFATAL_ERR_EN_BIT = 1;
    localparam int FATAL_ERR_EN_BIT = 2;
    localparam int UNSUP_REQ_EN_BIT = 3;
    localparam int RELAXED_ORDER_BIT = 4;
    localparam int MAX_PAYLOAD_LSB = 5;
    localparam int MAX_PAYLOAD_MSB = 7;
    localparam int EXT_TAG_EN_BIT = 8;
    localparam int PHANTOM_EN_BIT = 9;
    localparam int AUX_POWER_EN_BIT = 10;
    localparam int NO_SNOOP_BIT = 11;
    localparam int MAX_READ_REQ_LSB = 12;
    localparam int MAX_READ_REQ_MSB = 14;
    localparam int RESERVED_PRESERVE_BIT = 15;

    // field positions in payload_cap_status
    localparam int CAP_CODE_LSB = 0;
    localparam int CAP_CODE_MSB = 2;
    localparam int CAP_VALID_BIT = 3;

    // reset values and hardwired codes
    localparam logic ERR_EN_RESET = 1'b0;
    localparam logic AUX_POWER_EN_RESET = 1'b0;
    localparam logic [2:0] MAX_PAYLOAD_RESET = 3'h0;
    localparam logic [2:0] MAX_READ_REQ_CODE = 3'h0;
    localparam logic HARDWIRED_ZERO = 1'b0;
    localparam logic [2:0] CAP_CODE_STRAP_LOW = 3'h1;
    localparam logic [2:0] CAP_CODE_STRAP_HIGH = 3'h2;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage

//--- payload_cap_latch.sv
// captures the supported payload size capability from the strap after reset
`timescale 1ns/1ps

module payload_cap_latch
    import port_devctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic large_payload_strap,
    output logic [2:0] cap_code,
    output logic cap_valid
);

    // strap is sampled at the first edge after release, never by the reset itself
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cap_code <= CAP_CODE_STRAP_LOW;
            cap_valid <= 1'b0;
        end
        else if (!cap_valid)
        begin
            cap_code <= large_payload_strap ? CAP_CODE_STRAP_HIGH : CAP_CODE_STRAP_LOW;
            cap_valid <= 1'b1;
        end
    end

endmodule

//--- port_devctl_regs.sv
// device control register of one switch port, classic wishbone slave
//
// What this block does
// - bit 0 enables correctable error reporting, read-write, resets to zero.
// - bit 1 enables non-fatal error reporting, read-write, resets to zero.
// - bit 2 enables fatal error reporting, read-write, resets to zero.
// - bit 3 enables unsupported request reporting, read-write, resets to zero.
// - bit 4, relaxed ordering permission, is read-only and reads zero.
// - bits 7:5 hold a writable payload size setting, resetting to zero.
// - a payload code above the supported capability is stored as the capability.
// - bits 8 and 9 ignore writes and read zero.
// - bit 10 is a sticky read-write aux power enable, resetting to zero.
// - bit 11, no snoop permission, is read-only and reads zero.
// - bits 14:12, read request size, are hardwired to zero.
// - capability resets to 001b, then latches 001b with strap low, 010b with strap high after release.
`timescale 1ns/1ps

module port_devctl_regs
    import port_devctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic hot_reset,
    input wire logic large_payload_strap,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [SEL_W-1:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic corr_err_report_en,
    output logic nonfatal_err_report_en,
    output logic fatal_err_report_en,
    output logic unsup_req_report_en,
    output logic [2:0] max_payload_size,
    output logic aux_power_pm_en,
    output logic [2:0] payload_cap
);

    typedef enum logic [1:0]
    {
        HIT_NONE,
        HIT_CONTROL,
        HIT_CAP_STATUS
    } reg_hit_t;

    typedef enum logic
    {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_t;

    logic [2:0] cap_code;
    logic cap_valid;
    logic bus_req;
    logic commit;
    logic wr_commit;
    reg_hit_t hit;
    logic ctl_wr_lo;
    logic ctl_wr_hi;
    logic [2:0] next_max_payload;
    logic [REG_W-1:0] control_view;
    logic [DATA_W-1:0] next_rdata;
    bus_state_t bus_state;
    bus_state_t next_bus_state;

    // address decode shared by the write path and the read mux
    function automatic reg_hit_t decode_addr(input logic [ADDR_W-1:0] adr);
        reg_hit_t h;
        h = HIT_NONE;
        if (adr[ADDR_W-1:2] == PORT_DEVICE_CONTROL_OFFSET[ADDR_W-1:2])
        begin
            h = HIT_CONTROL;
        end
        else if (adr[ADDR_W-1:2] == PAYLOAD_CAP_STATUS_OFFSET[ADDR_W-1:2])
        begin
            h = HIT_CAP_STATUS;
        end
        return h;
    endfunction

    // limit a written payload code to what the port can carry
    function automatic logic [2:0] clamp_payload(
        input logic [2:0] written,
        input logic [2:0] cap
    );
        logic [2:0] c;
        c = written;
        if (written > cap)
        begin
            c = cap;
        end
        return c;
    endfunction

    // a byte lane of the control register opens only on the committing edge,
    // so both lanes share one decode and cannot drift apart
    function automatic logic lane_write(
        input logic commit_wr,
        input reg_hit_t reg_sel,
        input logic lane_sel
    );
        return commit_wr && (reg_sel == HIT_CONTROL) && lane_sel;
    endfunction

    payload_cap_latch u_cap
    (
        .clk(clk),
        .rst_n(rst_n),
        .large_payload_strap(large_payload_strap),
        .cap_code(cap_code),
        .cap_valid(cap_valid)
    );

    // bus handshake
    // a request is answered one cycle after it appears; the write lands on the
    // edge where the master sees ack, so a held request writes again on each ack
    assign bus_req = wb_cyc_i && wb_stb_i;
    assign commit = bus_req && wb_ack_o;
    assign wr_commit = commit && wb_we_i;
    assign hit = decode_addr(wb_adr_i);
    assign ctl_wr_lo = lane_write(wr_commit, hit, wb_sel_i[0]);
    assign ctl_wr_hi = lane_write(wr_commit, hit, wb_sel_i[1]);

    // one answer, then a forced idle cycle; a master that holds its request
    // past ack is therefore answered again after that idle cycle
    always_comb
    begin
        next_bus_state = BUS_IDLE;
        case (bus_state)
            BUS_IDLE:
            begin
                if (bus_req)
                begin
                    next_bus_state = BUS_ANSWER;
                end
            end
            BUS_ANSWER:
            begin
                next_bus_state = BUS_IDLE;
            end
            default:
            begin
                next_bus_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_state <= BUS_IDLE;
        end
        else
        begin
            bus_state <= next_bus_state;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            // unmapped addresses are acked too: reads give zero, writes drop
            wb_ack_o <= (next_bus_state == BUS_ANSWER);
        end
    end

    // error reporting enables
    // hot reset clears these like the configuration reset does
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            corr_err_report_en <= ERR_EN_RESET;
        end
        else if (hot_reset)
        begin
            corr_err_report_en <= ERR_EN_RESET;
        end
        else if (ctl_wr_lo)
        begin
            corr_err_report_en <= wb_dat_i[CORR_ERR_EN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nonfatal_err_report_en <= ERR_EN_RESET;
        end
        else if (hot_reset)
        begin
            nonfatal_err_report_en <= ERR_EN_RESET;
        end
        else if (ctl_wr_lo)
        begin
            nonfatal_err_report_en <= wb_dat_i[NONFATAL_ERR_EN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fatal_err_report_en <= ERR_EN_RESET;
        end
        else if (hot_reset)
        begin
            fatal_err_report_en <= ERR_EN_RESET;
        end
        else if (ctl_wr_lo)
        begin
            fatal_err_report_en <= wb_dat_i[FATAL_ERR_EN_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            unsup_req_report_en <= ERR_EN_RESET;
        end
        else if (hot_reset)
        begin
            unsup_req_report_en <= ERR_EN_RESET;
        end
        else if (ctl_wr_lo)
        begin
            unsup_req_report_en <= wb_dat_i[UNSUP_REQ_EN_BIT];
        end
    end

    // payload size setting
    always_comb
    begin
        next_max_payload = clamp_payload(wb_dat_i[MAX_PAYLOAD_MSB:MAX_PAYLOAD_LSB],
            cap_code);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            max_payload_size <= MAX_PAYLOAD_RESET;
        end
        else if (hot_reset)
        begin
            max_payload_size <= MAX_PAYLOAD_RESET;
        end
        else if (ctl_wr_lo)
        begin
            max_payload_size <= next_max_payload;
        end
    end

    // sticky aux power enable
    // only the power-on reset reaches it, so it rides out configuration
    // and hot resets; while rst_n is low writes cannot reach it anyway
    always_ff @(posedge clk or negedge por_n)
    begin
        if (!por_n)
        begin
            aux_power_pm_en <= AUX_POWER_EN_RESET;
        end
        else if (ctl_wr_hi)
        begin
            aux_power_pm_en <= wb_dat_i[AUX_POWER_EN_BIT];
        end
    end

    // capability mirror
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            payload_cap <= CAP_CODE_STRAP_LOW;
        end
        else
        begin
            payload_cap <= cap_code;
        end
    end

    // register view
    // the fixed-zero fields are wired here and never stored, so no write can
    // set them
    always_comb
    begin
        control_view = '0;
        control_view[CORR_ERR_EN_BIT] = corr_err_report_en;
        control_view[NONFATAL_ERR_EN_BIT] = nonfatal_err_report_en;
        control_view[FATAL_ERR_EN_BIT] = fatal_err_report_en;
        control_view[UNSUP_REQ_EN_BIT] = unsup_req_report_en;
        control_view[RELAXED_ORDER_BIT] = HARDWIRED_ZERO;
        control_view[MAX_PAYLOAD_MSB:MAX_PAYLOAD_LSB] = max_payload_size;
        control_view[EXT_TAG_EN_BIT] = HARDWIRED_ZERO;
        control_view[PHANTOM_EN_BIT] = HARDWIRED_ZERO;
        control_view[AUX_POWER_EN_BIT] = aux_power_pm_en;
        control_view[NO_SNOOP_BIT] = HARDWIRED_ZERO;
        control_view[MAX_READ_REQ_MSB:MAX_READ_REQ_LSB] = MAX_READ_REQ_CODE;
        control_view[RESERVED_PRESERVE_BIT] = HARDWIRED_ZERO;
    end

    always_comb
    begin
        next_rdata = READ_ZERO;
        case (hit)
            HIT_CONTROL:
            begin
                // status half of the dword is not kept here and reads zero
                next_rdata[REG_W-1:0] = control_view;
            end
            HIT_CAP_STATUS:
            begin
                next_rdata[CAP_CODE_MSB:CAP_CODE_LSB] = cap_code;
                next_rdata[CAP_VALID_BIT] = cap_valid;
            end
            default:
            begin
                next_rdata = READ_ZERO;
            end
        endcase
    end

    // read data is loaded with a read's ack and held through writes until the next read answer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_dat_o <= READ_ZERO;
        end
        else if (bus_req && !wb_ack_o && !wb_we_i)
        begin
            wb_dat_o <= next_rdata;
        end
    end

endmodule

//--- port_devctl_checker.sv
// concurrent checks on the ports of the device control register bank
`timescale 1ns/1ps

module port_devctl_checker
    import port_devctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic por_n,
    input wire logic hot_reset,
    input wire logic large_payload_strap,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [SEL_W-1:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    input wire logic [DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic corr_err_report_en,
    input wire logic nonfatal_err_report_en,
    input wire logic fatal_err_report_en,
    input wire logic unsup_req_report_en,
    input wire logic [2:0] max_payload_size,
    input wire logic aux_power_pm_en,
    input wire logic [2:0] payload_cap
);
    logic [2:0] clamp_exp;
    assign clamp_exp = (wb_dat_i[7:5] > payload_cap) ? payload_cap : wb_dat_i[7:5];
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a write lands at the edge that samples ack high
    sequence wr_hit;
        wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i
            && wb_adr_i[11:2] == PORT_DEVICE_CONTROL_OFFSET[11:2];
    endsequence
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held beyond one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    reset_clear_a: assert property ($rose(rst_n) |->
        !corr_err_report_en && max_payload_size == 3'h0)
        else $error("fields not cleared by reset");
    err_write_a: assert property (wr_hit and (wb_sel_i[0] && !hot_reset) |=>
        {unsup_req_report_en, fatal_err_report_en, nonfatal_err_report_en, corr_err_report_en}
        == $past(wb_dat_i[3:0])) else $error("enable write mismatch");
    payload_clamp_a: assert property (wr_hit and (wb_sel_i[0] && !hot_reset) |=>
        max_payload_size == $past(clamp_exp)) else $error("payload clamp mismatch");
    aux_write_a: assert property (wr_hit and wb_sel_i[1] |=>
        aux_power_pm_en == $past(wb_dat_i[10])) else $error("aux enable write mismatch");
    zero_bits_a: assert property (wb_ack_o |-> wb_dat_o[31:11] == 21'h0
        && wb_dat_o[9:8] == 2'h0 && !wb_dat_o[4]) else $error("hardwired bits read nonzero");
    hot_clear_a: assert property (hot_reset |=>
        !corr_err_report_en && !nonfatal_err_report_en && !fatal_err_report_en
        && !unsup_req_report_en && max_payload_size == 3'h0)
        else $error("hot reset did not clear");
    aux_keep_a: assert property (hot_reset && !wb_ack_o |=> $stable(aux_power_pm_en))
        else $error("aux enable lost on hot reset");
    cap_strap_a: assert property ($rose(rst_n) |-> ##2 payload_cap ==
        ($past(large_payload_strap, 2) ? CAP_CODE_STRAP_HIGH : CAP_CODE_STRAP_LOW))
        else $error("capability does not follow strap");
endmodule

bind port_devctl_regs port_devctl_checker port_devctl_checker_inst (.*);

//--- switch_port_device_control_reg_bench.sv
// self-checking bench for the device control register bank
`timescale 1ns/1ps

module switch_port_device_control_reg_bench
    import port_devctl_pkg::*;
;
    logic clk, rst_n, por_n, hot_reset, large_payload_strap, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [ADDR_W-1:0] wb_adr_i;
    logic [SEL_W-1:0] wb_sel_i;
    logic [DATA_W-1:0] wb_dat_i, wb_dat_o, q;
    logic wb_ack_o, corr_err_report_en, nonfatal_err_report_en, fatal_err_report_en;
    logic unsup_req_report_en, aux_power_pm_en;
    logic [2:0] max_payload_size, payload_cap;
    int error_cnt, compares, seed, m_en, m_mps, m_aux, m_cap, i;

    port_devctl_regs port_devctl_regs_inst
    (
        .clk(clk),
        .rst_n(rst_n),
        .por_n(por_n),
        .hot_reset(hot_reset),
        .large_payload_strap(large_payload_strap),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .corr_err_report_en(corr_err_report_en),
        .nonfatal_err_report_en(nonfatal_err_report_en),
        .fatal_err_report_en(fatal_err_report_en),
        .unsup_req_report_en(unsup_req_report_en),
        .max_payload_size(max_payload_size),
        .aux_power_pm_en(aux_power_pm_en),
        .payload_cap(payload_cap)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task stop_test;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #200000;
        error_cnt++;
        stop_test;
    end

    task cmp_read(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // port levels packed into one word so a single report line shows all
    task cmp_out;
        cmp_read({21'h0, aux_power_pm_en, max_payload_size, unsup_req_report_en,
            fatal_err_report_en, nonfatal_err_report_en, corr_err_report_en, payload_cap},
            32'({m_aux[0], m_mps[2:0], m_en[3:0], m_cap[2:0]}));
    endtask

    task wb(input logic we, input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        // no wait limit here: only the watchdog may end a hung request
        do
        begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    task wr(input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
        wb(1'b1, a, s, d);
        if (a[11:2] == PORT_DEVICE_CONTROL_OFFSET[11:2])
        begin
            if (s[0])
            begin
                m_en = d[3:0];
                m_mps = (d[7:5] > m_cap) ? m_cap : d[7:5];
            end
            if (s[1])
                m_aux = d[10];
        end
    endtask

    task chk;
        wb(1'b0, PORT_DEVICE_CONTROL_OFFSET, 4'hF, 32'h0);
        cmp_read(q, 32'(m_en | (m_mps << 5) | (m_aux << 10)));
        cmp_out;
    endtask

    // por clears the sticky aux enable, plain reset must not
    task do_reset(input logic full, input logic strap);
        rst_n <= 1'b0;
        por_n <= !full;
        large_payload_strap <= strap;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (2) @(posedge clk);
        m_en = 0;
        m_mps = 0;
        m_cap = strap ? 2 : 1;
        if (full)
            m_aux = 0;
    endtask

    task sweep;
        for (i = 0; i < 8; i++)
        begin
            wr(PORT_DEVICE_CONTROL_OFFSET, 4'h1, 32'(i << 5));
            chk;
        end
    endtask

    initial
    begin
        error_cnt = 0;
        compares = 0;
        m_aux = 0;
        seed = 16976;
        {rst_n, por_n, hot_reset, large_payload_strap, wb_cyc_i, wb_stb_i, wb_we_i} = 7'h0;
        {wb_adr_i, wb_sel_i, wb_dat_i} = 48'h0;
        do_reset(1'b1, 1'b0);
        chk;
        wb(1'b0, PAYLOAD_CAP_STATUS_OFFSET, 4'hF, 32'h0);
        cmp_read(q, 32'(8 + m_cap));
        $display("test reset done");
        for (i = 0; i < 24; i++)
        begin
            wr(PORT_DEVICE_CONTROL_OFFSET, 4'($random(seed)), $random(seed));
            chk;
        end
        $display("test random writes done");
        sweep;
        wr(12'h010, 4'hF, 32'hFFFF_FFFF);
        chk;
        wb(1'b0, 12'h010, 4'hF, 32'h0);
        cmp_read(q, 32'h0);
        $display("test clamp and unmapped done");
        wr(PORT_DEVICE_CONTROL_OFFSET, 4'h3, 32'h0000_FFFF);
        hot_reset <= 1'b1;
        @(posedge clk);
        hot_reset <= 1'b0;
        @(posedge clk);
        m_en = 0;
        m_mps = 0;
        chk;
        do_reset(1'b0, 1'b1);
        chk;
        sweep;
        do_reset(1'b1, 1'b1);
        chk;
        $display("test resets done");
        stop_test;
    end
endmodule
